// ### include/cis_pkg.sv
/*
  constants, opcodes and states shared by the execution slice.
  assumes a decoder outside has already split each instruction into fields.
*/
// Operation
// - exchange-all swaps three main pairs with their alternates at once
// - halt stops execution until an interrupt or reset
// - interrupt mode instructions select and retain mode 0, 1 or 2
// - immediate-port input loads the accumulator from the given port
// - port-select input loads the chosen general register from the port
// - memory increment reads, adds one, writes back to the same address
// - pair increment adds one to the full 16-bit pair
// - descending block input stores port byte, decrements pointer and counter
// - ascending block input stores port byte, increments pointer, decrements counter
// - conditional absolute jump loads the target only when condition holds
// - unconditional absolute jump always loads the 16-bit target
// - register jump loads the program counter from the named pair
// - relative jump adds the signed displacement to the program counter
// - conditional relative jump adds displacement only when condition holds
// - special load copies the interrupt vector base into the accumulator
// - special load copies the refresh counter into the accumulator
// - descending block move copies byte, decrements both pointers and count
// - ascending block move copies byte, increments pointers, decrements count
// - stack pointer load copies the named pair into the stack pointer
package cis_pkg;
  typedef enum logic [4:0] {
    CIS_SWAP_ALT  = 5'h00,
    CIS_HALT      = 5'h01,
    CIS_SEL_INT   = 5'h02,
    CIS_IN_IMM    = 5'h03,
    CIS_IN_PORT   = 5'h04,
    CIS_INC_MEM   = 5'h05,
    CIS_INC_PAIR  = 5'h06,
    CIS_BIN_DN    = 5'h07,
    CIS_BIN_DN_R  = 5'h08,
    CIS_BIN_UP    = 5'h09,
    CIS_BIN_UP_R  = 5'h0A,
    CIS_AJ_COND   = 5'h0B,
    CIS_AJ        = 5'h0C,
    CIS_AJ_PAIR   = 5'h0D,
    CIS_RJ        = 5'h0E,
    CIS_RJ_COND   = 5'h0F,
    CIS_ACC_IVEC  = 5'h10,
    CIS_ACC_RFSH  = 5'h11,
    CIS_BMV_DN    = 5'h12,
    CIS_BMV_DN_R  = 5'h13,
    CIS_BMV_UP    = 5'h14,
    CIS_BMV_UP_R  = 5'h15,
    CIS_SP_PAIR   = 5'h16,
    CIS_ST_PAIR   = 5'h17,
    CIS_SET_PAIR  = 5'h18,
    CIS_IVEC_ACC  = 5'h19
  } cis_op_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_IORD = 3'h1,
    S_MRD  = 3'h3,
    S_MWR  = 3'h2,
    S_MWR2 = 3'h6,
    S_HALT = 3'h4
  } cis_state_t;
  // general register indices; 7 names the accumulator
  localparam logic [2:0] R_HI   = 3'h0;
  localparam logic [2:0] R_LO   = 3'h1;
  localparam logic [2:0] R_ACC  = 3'h7;
  localparam logic [2:0] R_NONE = 3'h6;
  // pair codes
  localparam logic [1:0] P_CNT = 2'h0;
  localparam logic [1:0] P_DST = 2'h1;
  localparam logic [1:0] P_MEM = 2'h2;
  localparam logic [1:0] P_SP  = 2'h3;
  // flag bit positions
  localparam int F_C = 0;
  localparam int F_PV = 2;
  localparam int F_Z = 6;
  localparam int F_S = 7;
  // highest legal interrupt mode
  localparam logic [1:0] IM_MAX = 2'h2;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_SP   = 16'hFFFF;
endpackage

// ### test/cis_bus_model.sv
/*
  memory and port devices that sit on the processor bus of the execution slice.
  assumes single-cycle strobes and answers in the strobe cycle, no wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_bus_model (
  input  wire logic        mclk,      // clock
  input  wire logic [15:0] mem_addr,  // memory address
  input  wire logic        mem_rd,    // memory read strobe
  input  wire logic        mem_wr,    // memory write strobe
  input  wire logic [7:0]  mem_wdata, // memory write data
  input  wire logic [15:0] io_addr,   // port address
  input  wire logic        io_rd,     // port read strobe
  output logic      [7:0]  mem_rdata, // memory read data
  output logic      [7:0]  io_rdata   // port read data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_m;
  logic [7:0] last_i;

  initial begin
    last_m = 8'h00;
    last_i = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 7 + 3);
  end

  // released bus shows the inverse of the last byte so stale data never passes
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_m;
  assign io_rdata  = io_rd ? (io_addr[7:0] ^ io_addr[15:8] ^ 8'hA5) : ~last_i;

  always @(posedge mclk) begin
    if (mem_rd) last_m <= mem_rdata;
    if (io_rd) last_i <= io_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule
`default_nettype wire

// ### test/cis_exec_tb.sv
/*
  self-checking bench: the execution slice against a behavioural model.
  assumes cis_bus_model stands for memory and ports on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_exec_tb;
  import cis_pkg::*;
  logic        mclk, resetn, op_valid, intr_pin;
  cis_op_t     op_code;
  logic [2:0]  op_reg, op_cond;
  logic [1:0]  op_pair, op_len, int_mode;
  logic [15:0] op_imm, mem_addr, io_addr, pc, sp;
  logic [15:0] count_pair, destination_pointer_pair, memory_pointer_pair;
  logic [7:0]  flags, mem_rdata, io_rdata, mem_wdata, acc;
  logic        op_ready, op_done, halted, mem_rd, mem_wr, io_rd;
  int          miscompares, tests_run, m_pc, m_acc, m_mode, m_ivec, n_ops;
  int          m_pr[4], alt[3], em[int], wa[$];
  int          bp[4] = '{F_Z, F_C, F_PV, F_S};

  cis_exec dut (.mclk, .resetn, .op_valid, .op_code, .op_reg, .op_pair, .op_cond, .op_imm,
    .op_len, .flags, .intr_pin, .mem_rdata, .io_rdata, .op_ready, .op_done, .halted,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .io_addr, .io_rd, .pc, .sp, .acc, .count_pair,
    .destination_pointer_pair, .memory_pointer_pair, .int_mode);
  cis_bus_model bus (.mclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .io_addr, .io_rd,
    .mem_rdata, .io_rdata);

  always #25 mclk = ~mclk;

  task automatic tally_and_finish;
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input int e);
    tests_run++;
    if (s !== 16'(e)) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, s, 16'(e));
    end
  endtask

  function automatic int pb(int a);
    return ((a >> 8) ^ a ^ 'hA5) & 'hFF;
  endfunction

  function automatic int mx(int a);
    return em.exists(a) ? em[a] : (a * 7 + 3) & 'hFF;
  endfunction

  function automatic bit ct(int c);
    return flags[bp[c[2:1]]] == c[0];
  endfunction

  task automatic wr(int a, int v);
    em[a & 'hFFFF] = v & 'hFF;
    wa.push_back(a & 'hFFFF);
  endtask

  task automatic mdl;
    int o, d, t, r;
    o = m_pc;
    r = op_reg;
    d = (op_code inside {CIS_BIN_DN, CIS_BIN_DN_R, CIS_BMV_DN, CIS_BMV_DN_R}) ? 'hFFFF : 1;
    m_pc = (o + op_len) & 'hFFFF;
    case (op_code)
      CIS_SWAP_ALT: for (int i = 0; i < 3; i++) begin
        t = m_pr[i];
        m_pr[i] = alt[i];
        alt[i] = t;
      end
      CIS_SEL_INT: if (op_imm[1:0] != 2'h3) m_mode = op_imm[1:0];
      CIS_IN_IMM: m_acc = pb((m_acc << 8) | op_imm[7:0]);
      CIS_IN_PORT: begin
        t = pb(m_pr[0]);
        if (r == 7) m_acc = t;
        else if (r < 6 && r[0]) m_pr[r / 2] = (m_pr[r / 2] & 'hFF00) | t;
        else if (r < 6) m_pr[r / 2] = (m_pr[r / 2] & 'hFF) | (t << 8);
      end
      CIS_INC_MEM: wr(op_imm, mx(op_imm) + 1);
      CIS_INC_PAIR: m_pr[op_pair] = (m_pr[op_pair] + 1) & 'hFFFF;
      CIS_BIN_DN, CIS_BIN_DN_R, CIS_BIN_UP, CIS_BIN_UP_R: begin
        wr(m_pr[2], pb(m_pr[0]));
        m_pr[2] = (m_pr[2] + d) & 'hFFFF;
        m_pr[0] = (m_pr[0] - 'h100) & 'hFFFF;
        if (op_code inside {CIS_BIN_DN_R, CIS_BIN_UP_R} && m_pr[0] >= 'h100) m_pc = o;
      end
      CIS_BMV_DN, CIS_BMV_DN_R, CIS_BMV_UP, CIS_BMV_UP_R: begin
        wr(m_pr[1], mx(m_pr[2]));
        m_pr[1] = (m_pr[1] + d) & 'hFFFF;
        m_pr[2] = (m_pr[2] + d) & 'hFFFF;
        m_pr[0] = (m_pr[0] - 1) & 'hFFFF;
        if (op_code inside {CIS_BMV_DN_R, CIS_BMV_UP_R} && m_pr[0] != 0) m_pc = o;
      end
      CIS_AJ_COND: if (ct(op_cond)) m_pc = op_imm;
      CIS_AJ: m_pc = op_imm;
      CIS_AJ_PAIR: m_pc = m_pr[op_pair];
      CIS_RJ: m_pc = (o + int'($signed(op_imm[7:0]))) & 'hFFFF;
      CIS_RJ_COND: begin
        if (ct(op_cond & 3)) m_pc = (o + int'($signed(op_imm[7:0]))) & 'hFFFF;
      end
      CIS_ACC_IVEC: m_acc = m_ivec;
      CIS_IVEC_ACC: m_ivec = m_acc;
      // refresh starts at zero and steps once per earlier accepted op
      CIS_ACC_RFSH: m_acc = (n_ops - 1) & 'h7F;
      CIS_SP_PAIR: m_pr[3] = m_pr[op_pair];
      CIS_ST_PAIR: begin
        wr(op_imm, m_pr[op_pair]);
        wr(op_imm + 1, m_pr[op_pair] >> 8);
      end
      CIS_SET_PAIR: m_pr[op_pair] = op_imm;
      default: ;
    endcase
  endtask

  task automatic check_all;
    chk(pc, m_pc);
    chk(sp, m_pr[3]);
    chk(acc, m_acc);
    chk(count_pair, m_pr[0]);
    chk(destination_pointer_pair, m_pr[1]);
    chk(memory_pointer_pair, m_pr[2]);
    chk(int_mode, m_mode);
    chk(halted, 0);
    chk(op_ready, 1);
    foreach (wa[i]) chk(bus.mem[wa[i]], em[wa[i]]);
    wa.delete();
  endtask

  task automatic run(cis_op_t c, int r, int p, int cn, int im);
    int k;
    bit dn;
    op_code = c;
    op_reg = 3'(r);
    op_pair = 2'(p);
    op_cond = 3'(cn);
    op_imm = 16'(im);
    op_len = 2'($urandom_range(3, 1));
    flags = 8'($urandom);
    op_valid = 1;
    @(negedge mclk) dn = op_done;
    @(posedge mclk) #2 op_valid = 0;
    if (c == CIS_HALT) begin
      repeat (3) @(posedge mclk);
      #2 chk(halted, 1);
      intr_pin = 1;
    end
    for (k = 0; k < 40 && !dn; k++) @(negedge mclk) dn = op_done;
    @(posedge mclk) #2 intr_pin = 0;
    if (!dn) begin
      miscompares++;
      tally_and_finish;
    end
    n_ops++;
    mdl;
    check_all;
  endtask

  // repeating forms are re-offered until the program counter moves on
  task automatic rep(cis_op_t c, int n);
    int k, o;
    for (k = 1; k < 20; k++) begin
      o = m_pc;
      run(c, 0, 0, 0, 0);
      if (m_pc != o) break;
    end
    chk(k, n);
  endtask

  initial begin
    mclk = 0;
    resetn = 0;
    op_valid = 0;
    intr_pin = 0;
    op_code = CIS_SWAP_ALT;
    op_reg = 3'h0;
    op_pair = 2'h0;
    op_cond = 3'h0;
    op_imm = 16'h0000;
    op_len = 2'h1;
    flags = 8'h00;
    m_pr[3] = 'hFFFF;
    void'($urandom(32'hF9AB));
    repeat (2) @(posedge mclk);
    #2 resetn = 1;
    @(posedge mclk) #2 check_all;
    for (int i = 0; i < 3; i++) run(CIS_SET_PAIR, 0, i, 0, $urandom);
    run(CIS_SWAP_ALT, 0, 0, 0, 0);
    for (int i = 0; i < 3; i++) run(CIS_SET_PAIR, 0, i, 0, $urandom);
    run(CIS_SWAP_ALT, 0, 0, 0, 0);
    for (int i = 1; i < 5; i++) run(CIS_SEL_INT, 0, 0, 0, i & 3);
    run(CIS_IN_IMM, 0, 0, 0, $urandom);
    for (int i = 0; i < 8; i++) run(CIS_IN_PORT, i, 0, 0, 0);
    run(CIS_IVEC_ACC, 0, 0, 0, 0);
    run(CIS_IN_IMM, 0, 0, 0, $urandom);
    run(CIS_ACC_IVEC, 0, 0, 0, 0);
    // address 36 starts at FF so the first access sees the wrap
    run(CIS_INC_MEM, 0, 0, 0, 36);
    run(CIS_INC_MEM, 0, 0, 0, 36);
    run(CIS_SET_PAIR, 0, 0, 0, 'hFFFF);
    for (int i = 0; i < 4; i++) run(CIS_INC_PAIR, 0, i, 0, 0);
    run(CIS_SET_PAIR, 0, 0, 0, 'h0300);
    run(CIS_SET_PAIR, 0, 2, 0, $urandom);
    run(CIS_BIN_UP, 0, 0, 0, 0);
    run(CIS_BIN_DN, 0, 0, 0, 0);
    rep(CIS_BIN_UP_R, 1);
    run(CIS_SET_PAIR, 0, 0, 0, 'h0300);
    rep(CIS_BIN_DN_R, 3);
    run(CIS_SET_PAIR, 0, 0, 0, 3);
    run(CIS_SET_PAIR, 0, 1, 0, $urandom);
    rep(CIS_BMV_UP_R, 3);
    run(CIS_SET_PAIR, 0, 0, 0, 2);
    rep(CIS_BMV_DN_R, 2);
    run(CIS_BMV_UP, 0, 0, 0, 0);
    run(CIS_BMV_DN, 0, 0, 0, 0);
    for (int i = 0; i < 16; i++) run(CIS_AJ_COND, 0, 0, i & 7, $urandom);
    run(CIS_AJ, 0, 0, 0, $urandom);
    run(CIS_AJ_PAIR, 0, 2, 0, 0);
    run(CIS_RJ, 0, 0, 0, 'h80);
    run(CIS_RJ, 0, 0, 0, 'h7F);
    for (int i = 0; i < 16; i++) run(CIS_RJ_COND, 0, 0, i & 7, $urandom);
    run(CIS_ACC_RFSH, 0, 0, 0, 0);
    run(CIS_SWAP_ALT, 0, 0, 0, 0);
    run(CIS_ACC_RFSH, 0, 0, 0, 0);
    for (int i = 0; i < 3; i++) run(CIS_SP_PAIR, 0, i, 0, 0);
    for (int i = 0; i < 4; i++) run(CIS_ST_PAIR, 0, i, 0, i == 3 ? 'hFFFF : $urandom);
    run(CIS_HALT, 0, 0, 0, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ### verilog/cis_cond.sv
/*
  condition evaluator for the conditional jumps.
  assumes flags come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_cond
  import cis_pkg::*;
(
  input  wire logic [2:0] cond,  // condition code
  input  wire logic [7:0] flags, // processor flags
  output logic            hold   // condition true
);
  always_comb begin
    case (cond)
      3'h0:    hold = !flags[F_Z];
      3'h1:    hold = flags[F_Z];
      3'h2:    hold = !flags[F_C];
      3'h3:    hold = flags[F_C];
      3'h4:    hold = !flags[F_PV];
      3'h5:    hold = flags[F_PV];
      3'h6:    hold = !flags[F_S];
      default: hold = flags[F_S];
    endcase
  end
endmodule
`default_nettype wire

// ### verilog/cis_exec.sv
/*
  execution slice: register bank, sequencer and memory/port bus strobes.
  assumes memory and port devices answer combinationally in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_exec
  import cis_pkg::*;
(
  input  wire logic        mclk,      // clock
  input  wire logic        resetn,    // sync reset, active low
  input  wire logic        op_valid,  // operation offered
  input  wire cis_op_t     op_code,   // decoded operation
  input  wire logic [2:0]  op_reg,    // general register select
  input  wire logic [1:0]  op_pair,   // pair select
  input  wire logic [2:0]  op_cond,   // condition code
  input  wire logic [15:0] op_imm,    // address, data or displacement
  input  wire logic [1:0]  op_len,    // instruction length in bytes
  input  wire logic [7:0]  flags,     // current flags
  input  wire logic        intr_pin,  // interrupt request pin
  input  wire logic [7:0]  mem_rdata, // memory read data
  input  wire logic [7:0]  io_rdata,  // port read data
  output logic             op_ready,  // able to take an operation
  output logic             op_done,   // operation finished
  output logic             halted,    // in halt
  output logic [15:0]      mem_addr,  // memory address
  output logic             mem_rd,    // memory read strobe
  output logic             mem_wr,    // memory write strobe
  output logic [7:0]       mem_wdata, // memory write data
  output logic [15:0]      io_addr,   // port address
  output logic             io_rd,     // port read strobe
  output logic [15:0]      pc,        // program counter
  output logic [15:0]      sp,        // stack pointer
  output logic [7:0]       acc,       // accumulator
  output logic [15:0]      count_pair,               // counter pair
  output logic [15:0]      destination_pointer_pair, // destination pair
  output logic [15:0]      memory_pointer_pair,      // memory pointer pair
  output logic [1:0]       int_mode   // interrupt response mode
);
  cis_state_t  state_reg;
  cis_op_t     op_reg_q;
  logic [2:0]  dst_reg;
  logic [1:0]  len_reg;
  logic [7:0]  gr_reg [0:5];
  logic [7:0]  alt_reg [0:5];
  logic [7:0]  acc_reg;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [15:0] sp_reg;
  logic [7:0]  ivec_reg;
  logic [7:0]  rfsh_reg;
  logic [1:0]  mode_reg;
  logic [15:0] addr_reg;
  logic [15:0] io_addr_reg;
  logic [7:0]  wdata_reg;
  logic        intr_s1_reg;
  logic        intr_s2_reg;
  logic        accept;
  logic        cond_hold;
  logic [2:0]  cond_sel;
  logic        blk_end;
  logic        is_up;
  logic        is_move;
  logic        is_rep;
  logic        again;
  logic [15:0] cnt_w;
  logic [15:0] dst_w;
  logic [15:0] mem_w;
  logic [15:0] sel_w;
  logic [15:0] rel_w;

  assign cnt_w = {gr_reg[0], gr_reg[1]};
  assign dst_w = {gr_reg[2], gr_reg[3]};
  assign mem_w = {gr_reg[4], gr_reg[5]};
  assign rel_w = pc_reg + {{8{op_imm[7]}}, op_imm[7:0]};

  always_comb begin
    case (op_pair)
      P_CNT:   sel_w = cnt_w;
      P_DST:   sel_w = dst_w;
      P_MEM:   sel_w = mem_w;
      default: sel_w = sp_reg;
    endcase
  end

  // relative forms only see the four zero and carry codes
  assign cond_sel = (op_code == CIS_RJ_COND) ? {1'b0, op_cond[1:0]} : op_cond;

  cis_cond u_cond (
    .cond  (cond_sel),
    .flags (flags),
    .hold  (cond_hold)
  );

  // the pin is asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      intr_s1_reg <= 1'b0;
      intr_s2_reg <= 1'b0;
    end else begin
      intr_s1_reg <= intr_pin;
      intr_s2_reg <= intr_s1_reg;
    end
  end

  assign accept   = op_valid && op_ready;
  assign op_ready = (state_reg == S_IDLE);
  assign halted   = (state_reg == S_HALT);
  assign mem_rd   = (state_reg == S_MRD);
  assign mem_wr   = (state_reg == S_MWR) || (state_reg == S_MWR2);
  assign io_rd    = (state_reg == S_IORD);
  assign is_up    = (op_reg_q == CIS_BIN_UP) || (op_reg_q == CIS_BIN_UP_R) ||
                    (op_reg_q == CIS_BMV_UP) || (op_reg_q == CIS_BMV_UP_R);
  assign is_move  = (op_reg_q >= CIS_BMV_DN) && (op_reg_q <= CIS_BMV_UP_R);
  assign is_rep   = (op_reg_q == CIS_BIN_DN_R) || (op_reg_q == CIS_BIN_UP_R) ||
                    (op_reg_q == CIS_BMV_DN_R) || (op_reg_q == CIS_BMV_UP_R);
  assign blk_end  = (state_reg == S_MWR) && (op_reg_q != CIS_ST_PAIR) &&
                    (op_reg_q != CIS_INC_MEM);
  // counter about to reach zero ends the loop
  assign again    = is_rep && (is_move ? (cnt_w != 16'h0001) : (gr_reg[0] != 8'h01));

  always_comb begin
    op_done = 1'b0;
    if (accept) begin
      case (op_code)
        CIS_IN_IMM, CIS_IN_PORT, CIS_INC_MEM, CIS_ST_PAIR, CIS_HALT,
        CIS_BIN_DN, CIS_BIN_DN_R, CIS_BIN_UP, CIS_BIN_UP_R,
        CIS_BMV_DN, CIS_BMV_DN_R, CIS_BMV_UP, CIS_BMV_UP_R: op_done = 1'b0;
        default: op_done = 1'b1;
      endcase
    end else if (state_reg == S_IORD) begin
      op_done = (op_reg_q == CIS_IN_IMM) || (op_reg_q == CIS_IN_PORT);
    end else if (state_reg == S_MWR) begin
      op_done = (op_reg_q != CIS_ST_PAIR);
    end else if (state_reg == S_MWR2) begin
      op_done = 1'b1;
    end else if (state_reg == S_HALT) begin
      op_done = intr_s2_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (accept) begin
            case (op_code)
              CIS_IN_IMM, CIS_IN_PORT, CIS_BIN_DN, CIS_BIN_DN_R,
              CIS_BIN_UP, CIS_BIN_UP_R: state_reg <= S_IORD;
              CIS_INC_MEM, CIS_BMV_DN, CIS_BMV_DN_R,
              CIS_BMV_UP, CIS_BMV_UP_R: state_reg <= S_MRD;
              CIS_ST_PAIR: state_reg <= S_MWR;
              CIS_HALT:    state_reg <= S_HALT;
              default:     state_reg <= S_IDLE;
            endcase
          end
        end
        S_IORD: begin
          if ((op_reg_q == CIS_IN_IMM) || (op_reg_q == CIS_IN_PORT)) begin
            state_reg <= S_IDLE;
          end else begin
            state_reg <= S_MWR;
          end
        end
        S_MRD:  state_reg <= S_MWR;
        S_MWR:  state_reg <= (op_reg_q == CIS_ST_PAIR) ? S_MWR2 : S_IDLE;
        S_MWR2: state_reg <= S_IDLE;
        S_HALT: begin
          if (intr_s2_reg) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      op_reg_q <= CIS_HALT;
      dst_reg  <= R_NONE;
      len_reg  <= 2'h0;
    end else if (accept) begin
      op_reg_q <= op_code;
      dst_reg  <= op_reg;
      len_reg  <= op_len;
    end
  end

  // bus address and write data
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      addr_reg    <= RST_WORD;
      io_addr_reg <= RST_WORD;
      wdata_reg   <= RST_BYTE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (accept) begin
            io_addr_reg <= (op_code == CIS_IN_IMM) ? {acc_reg, op_imm[7:0]} : cnt_w;
            addr_reg    <= ((op_code == CIS_INC_MEM) || (op_code == CIS_ST_PAIR)) ?
                           op_imm : mem_w;
            wdata_reg   <= sel_w[7:0];
          end
        end
        S_IORD: wdata_reg <= io_rdata;
        S_MRD: begin
          if (op_reg_q == CIS_INC_MEM) begin
            wdata_reg <= mem_rdata + 8'h01;
          end else begin
            wdata_reg <= mem_rdata;
            addr_reg  <= dst_w;
          end
        end
        S_MWR: begin
          if (op_reg_q == CIS_ST_PAIR) begin
            addr_reg  <= addr_reg + 16'h0001;
            wdata_reg <= sel_w[15:8];
          end
        end
        default: addr_reg <= addr_reg;
      endcase
    end
  end

  // general registers, alternates and accumulator
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < 6; i++) begin
        gr_reg[i]  <= RST_BYTE;
        alt_reg[i] <= RST_BYTE;
      end
      acc_reg <= RST_BYTE;
    end else if (accept) begin
      case (op_code)
        CIS_SWAP_ALT: begin
          for (int i = 0; i < 6; i++) begin
            gr_reg[i]  <= alt_reg[i];
            alt_reg[i] <= gr_reg[i];
          end
        end
        CIS_INC_PAIR, CIS_SET_PAIR: begin
          if (op_pair != P_SP) begin
            {gr_reg[{op_pair, 1'b0}], gr_reg[{op_pair, 1'b1}]} <=
              (op_code == CIS_SET_PAIR) ? op_imm : sel_w + 16'h0001;
          end
        end
        CIS_ACC_IVEC: acc_reg <= ivec_reg;
        CIS_ACC_RFSH: acc_reg <= rfsh_reg;
        default: acc_reg <= acc_reg;
      endcase
    end else if (state_reg == S_IORD) begin
      if (op_reg_q == CIS_IN_IMM) begin
        acc_reg <= io_rdata;
      end else if (op_reg_q == CIS_IN_PORT) begin
        if (dst_reg == R_ACC) begin
          acc_reg <= io_rdata;
        end else if (dst_reg < R_NONE) begin
          gr_reg[dst_reg] <= io_rdata;
        end
      end
    end else if (blk_end) begin
      {gr_reg[4], gr_reg[5]} <= is_up ? mem_w + 16'h0001 : mem_w - 16'h0001;
      if (is_move) begin
        {gr_reg[2], gr_reg[3]} <= is_up ? dst_w + 16'h0001 : dst_w - 16'h0001;
        {gr_reg[0], gr_reg[1]} <= cnt_w - 16'h0001;
      end else begin
        gr_reg[R_HI] <= gr_reg[R_HI] - 8'h01;
      end
    end
  end

  always_comb begin
    pc_next = pc_reg + {14'h0000, len_reg};
    if (accept) begin
      pc_next = pc_reg + {14'h0000, op_len};
      case (op_code)
        CIS_AJ_COND: if (cond_hold) pc_next = op_imm;
        CIS_AJ:      pc_next = op_imm;
        CIS_AJ_PAIR: pc_next = sel_w;
        CIS_RJ:      pc_next = rel_w;
        CIS_RJ_COND: if (cond_hold) pc_next = rel_w;
        default:     pc_next = pc_reg + {14'h0000, op_len};
      endcase
    end else if (blk_end && again) begin
      // unfinished pass leaves pc on the instruction so it is fetched again
      pc_next = pc_reg;
    end
  end

  // multi-cycle ops move pc only at done, so a repeat pass can leave it in place;
  // halt advances pc on entry, so leaving halt must not advance again
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pc_reg <= RST_WORD;
    end else if ((op_done && (state_reg != S_HALT)) || (accept && (op_code == CIS_HALT))) begin
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sp_reg <= RST_SP;
    end else if (accept && (op_code == CIS_SP_PAIR)) begin
      sp_reg <= sel_w;
    end else if (accept && (op_pair == P_SP)) begin
      if (op_code == CIS_INC_PAIR) begin
        sp_reg <= sp_reg + 16'h0001;
      end else if (op_code == CIS_SET_PAIR) begin
        sp_reg <= op_imm;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mode_reg <= 2'h0;
      ivec_reg <= RST_BYTE;
    end else if (accept) begin
      // mode 3 does not exist, so it leaves the mode alone
      if ((op_code == CIS_SEL_INT) && (op_imm[1:0] <= IM_MAX)) begin
        mode_reg <= op_imm[1:0];
      end
      if (op_code == CIS_IVEC_ACC) begin
        ivec_reg <= acc_reg;
      end
    end
  end

  // refresh counts seven bits; bit 7 keeps its reset value, nothing writes it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rfsh_reg <= RST_BYTE;
    end else if (accept) begin
      rfsh_reg <= {rfsh_reg[7], rfsh_reg[6:0] + 7'h01};
    end
  end

  assign mem_addr   = addr_reg;
  assign mem_wdata  = wdata_reg;
  assign io_addr    = io_addr_reg;
  assign pc         = pc_reg;
  assign sp         = sp_reg;
  assign acc        = acc_reg;
  assign count_pair = cnt_w;
  assign destination_pointer_pair = dst_w;
  assign memory_pointer_pair      = mem_w;
  assign int_mode   = mode_reg;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_swap_bank: assert property (accept && op_code == CIS_SWAP_ALT |=>
    count_pair == {$past(alt_reg[0]), $past(alt_reg[1])} &&
    alt_reg[4] == $past(gr_reg[4]))
    else $error("bank swap wrong");
  a_halt_hold: assert property (halted && !intr_s2_reg |=> halted && !op_ready)
    else $error("left halt without interrupt");
  a_int_mode: assert property (accept && op_code == CIS_SEL_INT && op_imm[1:0] <= IM_MAX
    |=> int_mode == $past(op_imm[1:0]))
    else $error("mode not kept");
  a_in_acc: assert property (io_rd && op_reg_q == CIS_IN_IMM |=>
    acc == $past(io_rdata) && op_ready)
    else $error("port byte not in acc");
  a_inc_mem: assert property (mem_rd && op_reg_q == CIS_INC_MEM |=>
    mem_wr && mem_wdata == 8'($past(mem_rdata) + 8'h01) && mem_addr == $past(mem_addr))
    else $error("memory increment wrong");
  a_jump_abs: assert property (accept && op_code == CIS_AJ |=> pc == $past(op_imm))
    else $error("jump target wrong");
  a_jump_rel: assert property (accept && op_code == CIS_RJ |=>
    pc == 16'($past(pc) + {{8{$past(op_imm[7])}}, $past(op_imm[7:0])}))
    else $error("relative jump wrong");
  a_sp_load: assert property (accept && op_code == CIS_SP_PAIR |=> sp == $past(sel_w))
    else $error("stack pointer load wrong");
  a_store_order: assert property (mem_wr && op_reg_q == CIS_ST_PAIR &&
    state_reg == S_MWR |=> mem_wr && mem_addr == 16'($past(mem_addr) + 16'h0001))
    else $error("pair store order wrong");
  a_block_step: assert property (blk_end && is_move && is_up |=>
    count_pair == 16'($past(count_pair) - 16'h0001) && op_ready)
    else $error("block move step wrong");

  c_halt_exit: cover property (halted ##1 !halted);
  c_repeat: cover property (blk_end && again ##1 accept && op_code == op_reg_q);
  c_store: cover property (state_reg == S_MWR ##1 state_reg == S_MWR2);
endmodule
`default_nettype wire
